// ==== hw/cem_fifo.sv ====
// fifo: parameterised valid/ready buffer
`timescale 1ns/1ps
module cem_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cem_fifo

// ==== hw/cem_pkg.sv ====
// package: constants for the completion entry and moderation block
package cem_pkg;
    localparam int unsigned ENTRY_W      = 512;
    localparam int unsigned QID_W        = 4;
    localparam int unsigned NUM_Q        = 16;
    localparam int unsigned IDX_W        = 16;
    localparam int unsigned POS_W        = 9;
    localparam int unsigned NUM_OPT      = 7;
    localparam logic [2:0]  IDX_NONE     = 3'h7;
    localparam int unsigned FIFO_DEPTH   = 8;
    // register map, byte addresses
    localparam logic [11:0] REG_FMT_BASE = 12'hBC4;
    localparam logic [11:0] REG_FMT_LAST = 12'hBDC;
    localparam int unsigned FMT_COL_LSB  = 0;
    localparam int unsigned FMT_ERR_LSB  = 16;
    // compile-time bit positions of colour and error options
    localparam logic [POS_W-1:0] COL_POS [NUM_OPT] = '{9'h001, 9'h03F, 9'h07F, 9'h0FF,
                                                       9'h1FF, 9'h000, 9'h002};
    localparam logic [POS_W-1:0] ERR_POS [NUM_OPT] = '{9'h002, 9'h03E, 9'h07E, 9'h0FE,
                                                       9'h1FE, 9'h001, 9'h003};
    // entry sizes
    localparam logic [1:0] SIZE_8B  = 2'h0;
    localparam logic [1:0] SIZE_16B = 2'h1;
    localparam logic [1:0] SIZE_32B = 2'h2;
    localparam logic [1:0] SIZE_64B = 2'h3;
    // moderation modes
    localparam logic [2:0] MODE_DIS   = 3'h0;
    localparam logic [2:0] MODE_EVERY = 3'h1;
    localparam logic [2:0] MODE_UCNT  = 3'h2;
    localparam logic [2:0] MODE_USER  = 3'h3;
    localparam logic [2:0] MODE_UTMR  = 3'h4;
    localparam logic [2:0] MODE_UTC   = 3'h5;
    typedef enum logic {CEM_ST_SERVICE, CEM_ST_ARMED} cem_ist_t;
endpackage : cem_pkg

// ==== hw/cem_top.sv ====
// completion entry formatting and per-queue interrupt/status moderation
`timescale 1ns/1ps
module cem_top (
    input  wire logic                         mclk,
    input  wire logic                         nrst,
    // completion packet from user logic
    input  wire logic                         cmpt_valid,
    output logic                              cmpt_ready,
    input  wire logic [cem_pkg::ENTRY_W-1:0]  cmpt_data,
    input  wire logic [cem_pkg::QID_W-1:0]    cmpt_qid,
    input  wire logic [1:0]                   cmpt_size,
    input  wire logic                         cmpt_user_trig,
    input  wire logic [2:0]                   stream_color_position_index,
    input  wire logic [2:0]                   stream_error_position_index,
    // software consumer-index update
    input  wire logic                         cidx_upd_valid,
    input  wire logic [cem_pkg::QID_W-1:0]    cidx_upd_qid,
    input  wire logic [cem_pkg::IDX_W-1:0]    cidx_upd_value,
    input  wire logic                         cidx_upd_full,
    input  wire logic [2:0]                   cidx_upd_mode,
    input  wire logic                         cidx_upd_en_int,
    input  wire logic                         cidx_upd_en_stat,
    input  wire logic [cem_pkg::IDX_W-1:0]    cidx_upd_threshold,
    input  wire logic [cem_pkg::IDX_W-1:0]    cidx_upd_timer,
    // per-queue colour bit value and timer tick
    input  wire logic [cem_pkg::NUM_Q-1:0]    queue_color,
    input  wire logic                         timer_tick,
    // entry written to the ring
    output logic                              entry_valid,
    input  wire logic                         entry_ready,
    output logic      [cem_pkg::ENTRY_W-1:0]  entry_data,
    output logic      [cem_pkg::QID_W-1:0]    entry_qid,
    // moderation outputs
    output logic                              irq_valid,
    output logic      [cem_pkg::QID_W-1:0]    irq_qid,
    output logic                              stat_valid,
    output logic      [cem_pkg::QID_W-1:0]    stat_qid,
    // format register read port
    input  wire logic                         reg_rd,
    input  wire logic [11:0]                  reg_addr,
    output logic      [31:0]                  reg_rdata
);
    localparam int unsigned EW = cem_pkg::ENTRY_W;
    localparam int unsigned QW = cem_pkg::QID_W;
    localparam int unsigned NQ = cem_pkg::NUM_Q;
    localparam int unsigned IW = cem_pkg::IDX_W;
    localparam int unsigned FW = EW + QW + 1;

    // ****************************************************************
    // entry formatting
    // ****************************************************************
    function automatic logic [EW-1:0] size_mask(input logic [1:0] sz);
        unique case (sz)
            cem_pkg::SIZE_8B:  size_mask = {{(EW-64){1'b0}}, {64{1'b1}}};
            cem_pkg::SIZE_16B: size_mask = {{(EW-128){1'b0}}, {128{1'b1}}};
            cem_pkg::SIZE_32B: size_mask = {{(EW-256){1'b0}}, {256{1'b1}}};
            cem_pkg::SIZE_64B: size_mask = {EW{1'b1}};
        endcase
    endfunction : size_mask

    logic [EW-1:0] fmt_entry;
    always_comb begin
        // payload kept as sent, bits beyond the entry size cleared
        fmt_entry = cmpt_data & size_mask(cmpt_size);
        // index seven keeps user data at that spot
        if (stream_color_position_index != cem_pkg::IDX_NONE) begin
            fmt_entry[cem_pkg::COL_POS[stream_color_position_index]] =
                queue_color[cmpt_qid];
        end
        if (stream_error_position_index != cem_pkg::IDX_NONE) begin
            fmt_entry[cem_pkg::ERR_POS[stream_error_position_index]] = 1'b0;
        end
    end

    // ****************************************************************
    // output buffer
    // ****************************************************************
    logic          fifo_in_ready;
    logic [FW-1:0] fifo_out;
    logic          pkt_take;
    logic          pkt_sent;

    // no data packet is needed for a completion
    assign cmpt_ready = fifo_in_ready;
    assign pkt_take   = cmpt_valid && cmpt_ready;
    assign pkt_sent   = entry_valid && entry_ready;

    // eight entries let user logic run ahead of ring writes
    cem_fifo #(
        .WIDTH (FW),
        .DEPTH (cem_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (cmpt_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({cmpt_user_trig, cmpt_qid, fmt_entry}),
        .out_valid (entry_valid),
        .out_ready (entry_ready),
        .out_data  (fifo_out)
    );

    logic          sent_trig;
    logic [QW-1:0] sent_qid;
    assign entry_data = fifo_out[EW-1:0];
    assign entry_qid  = fifo_out[EW+QW-1:EW];
    assign sent_qid   = entry_qid;
    assign sent_trig  = fifo_out[FW-1];

    // ****************************************************************
    // per-queue context
    // ****************************************************************
    logic [2:0]    mode_r   [NQ];
    logic          en_int_r [NQ];
    logic          en_st_r  [NQ];
    logic [IW-1:0] thr_r    [NQ];
    logic [IW-1:0] tper_r   [NQ];
    logic [IW-1:0] tcnt_r   [NQ];
    logic          trun_r   [NQ];
    logic [IW-1:0] pidx_r   [NQ];
    logic [IW-1:0] cidx_r   [NQ];
    logic          upend_r  [NQ];
    logic          texp_r   [NQ];
    cem_pkg::cem_ist_t ist_r [NQ];
    logic [NQ-1:0] fire;
    logic [NQ-1:0] grant;

    genvar q;
    generate
        for (q = 0; q < NQ; q++) begin : g_q
            logic          upd;
            logic          wr;
            logic          done;
            logic [IW-1:0] unread;
            logic          cnt_hit;
            logic          ev_user;
            logic          trig;
            logic          drained;
            logic          tmr_hit;

            assign upd     = cidx_upd_valid && (cidx_upd_qid == QW'(q));
            assign wr      = pkt_take && (cmpt_qid == QW'(q));
            assign done    = pkt_sent && (sent_qid == QW'(q));
            assign unread  = pidx_r[q] - cidx_r[q];
            assign cnt_hit = (unread > thr_r[q]);
            assign ev_user = (done && sent_trig) || upend_r[q];
            // update reading to the end drops remembered triggers
            assign drained = upd && (pidx_r[q] == cidx_upd_value);
            // expiry with nothing unread is kept and counts once an entry is unread
            assign tmr_hit = texp_r[q] && (unread != '0);

            always_comb begin
                unique case (mode_r[q])
                    cem_pkg::MODE_EVERY: trig = (unread != '0);
                    cem_pkg::MODE_USER:  trig = ev_user;
                    cem_pkg::MODE_UCNT:  trig = ev_user || cnt_hit;
                    cem_pkg::MODE_UTMR:  trig = ev_user || tmr_hit;
                    cem_pkg::MODE_UTC:   trig = ev_user || tmr_hit || cnt_hit;
                    default:             trig = 1'b0;
                endcase
            end

            // fire only from armed state, which holds one interrupt at most
            assign fire[q] = (ist_r[q] == cem_pkg::CEM_ST_ARMED) && trig &&
                             (en_int_r[q] || en_st_r[q]) && !upd;

            // mode and enables replaced only by a full update
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    mode_r[q]   <= cem_pkg::MODE_DIS;
                    en_int_r[q] <= 1'b0;
                    en_st_r[q]  <= 1'b0;
                    thr_r[q]    <= '0;
                    tper_r[q]   <= '0;
                end else if (upd && cidx_upd_full) begin
                    mode_r[q]   <= cidx_upd_mode;
                    en_int_r[q] <= cidx_upd_en_int;
                    en_st_r[q]  <= cidx_upd_en_stat;
                    thr_r[q]    <= cidx_upd_threshold;
                    tper_r[q]   <= cidx_upd_timer;
                end
            end

            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pidx_r[q] <= '0;
                    cidx_r[q] <= '0;
                end else begin
                    if (done) begin
                        pidx_r[q] <= pidx_r[q] + 1'b1;
                    end
                    if (upd) begin
                        cidx_r[q] <= cidx_upd_value;
                    end
                end
            end

            // start awaiting service; an update arms the queue
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    ist_r[q] <= cem_pkg::CEM_ST_SERVICE;
                end else if (upd) begin
                    ist_r[q] <= cem_pkg::CEM_ST_ARMED;
                end else if (grant[q]) begin
                    ist_r[q] <= cem_pkg::CEM_ST_SERVICE;
                end
            end

            // user request remembered while outstanding; set beats a drain clear, a grant clears instead of setting
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    upend_r[q] <= 1'b0;
                end else if (done && sent_trig && !grant[q]) begin
                    upend_r[q] <= 1'b1;
                end else if (grant[q] || drained) begin
                    upend_r[q] <= 1'b0;
                end
            end

            // per-queue timer, restarted by an update
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    tcnt_r[q] <= '0;
                    trun_r[q] <= 1'b0;
                    texp_r[q] <= 1'b0;
                end else begin
                    if (upd || (wr && !trun_r[q])) begin
                        // a full update starts with its new period
                        if (upd && cidx_upd_full) begin
                            tcnt_r[q] <= cidx_upd_timer;
                        end else begin
                            tcnt_r[q] <= tper_r[q];
                        end
                        trun_r[q] <= 1'b1;
                    end else if (trun_r[q] && timer_tick) begin
                        if (tcnt_r[q] == '0) begin
                            trun_r[q] <= 1'b0;
                        end else begin
                            tcnt_r[q] <= tcnt_r[q] - 1'b1;
                        end
                    end
                    if (trun_r[q] && timer_tick && tcnt_r[q] == '0 && !upd) begin
                        texp_r[q] <= 1'b1;
                    end else if (grant[q] || drained) begin
                        texp_r[q] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // interrupt and status outputs, lowest queue first
    // ****************************************************************
    logic          sel_any;
    logic [QW-1:0] sel_q;
    always_comb begin
        sel_any = 1'b0;
        sel_q   = '0;
        for (int i = NQ - 1; i >= 0; i--) begin
            if (fire[i]) begin
                sel_any = 1'b1;
                sel_q   = QW'(i);
            end
        end
    end

    // only the reported queue leaves the armed state
    // other firing queues stay armed and fire in later cycles
    always_comb begin
        grant = '0;
        if (sel_any) begin
            grant[sel_q] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_valid  <= 1'b0;
            stat_valid <= 1'b0;
            irq_qid    <= '0;
            stat_qid   <= '0;
        end else begin
            irq_valid  <= sel_any && en_int_r[sel_q];
            stat_valid <= sel_any && en_st_r[sel_q];
            irq_qid    <= sel_q;
            stat_qid   <= sel_q;
        end
    end

    // ****************************************************************
    // format registers
    // ****************************************************************
    // unlisted and unaligned addresses read zero
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = '0;
        for (int i = 0; i < cem_pkg::NUM_OPT; i++) begin
            if (reg_addr == cem_pkg::REG_FMT_BASE + 12'(4 * i)) begin
                rd_nxt[cem_pkg::FMT_COL_LSB +: cem_pkg::POS_W] = cem_pkg::COL_POS[i];
                rd_nxt[cem_pkg::FMT_ERR_LSB +: cem_pkg::POS_W] = cem_pkg::ERR_POS[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_nxt;
        end
    end
endmodule : cem_top

// ==== tb/cem_assertions.sv ====
// checker: port-level assertions for the completion entry and moderation block
`timescale 1ns/1ps
module cem_assertions (
    input wire logic         mclk,
    input wire logic         nrst,
    input wire logic         cmpt_valid,
    input wire logic         cmpt_ready,
    input wire logic [511:0] cmpt_data,
    input wire logic [3:0]   cmpt_qid,
    input wire logic [1:0]   cmpt_size,
    input wire logic [2:0]   stream_color_position_index,
    input wire logic [2:0]   stream_error_position_index,
    input wire logic         cidx_upd_valid,
    input wire logic [3:0]   cidx_upd_qid,
    input wire logic         entry_valid,
    input wire logic         entry_ready,
    input wire logic [511:0] entry_data,
    input wire logic [3:0]   entry_qid,
    input wire logic         irq_valid,
    input wire logic [3:0]   irq_qid,
    input wire logic         stat_valid,
    input wire logic         reg_rd,
    input wire logic [11:0]  reg_addr,
    input wire logic [31:0]  reg_rdata
);
    logic armed_r;
    wire  take  = cmpt_valid && cmpt_ready && !entry_valid;
    wire  both7 = stream_color_position_index == 3'h7 && stream_error_position_index == 3'h7;
    // options 0, 5 and 6 sit below bit 64, so an 8-byte entry keeps them
    wire  low   = stream_color_position_index inside {3'h0, 3'h5, 3'h6, 3'h7}
               && stream_error_position_index inside {3'h0, 3'h5, 3'h6, 3'h7};
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            armed_r <= 1'b0;
        end else if (cidx_upd_valid) begin
            armed_r <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_hold; entry_valid && !entry_ready |=> $stable(entry_data) && $stable(entry_qid);
    endproperty
    a_hold: assert property (p_hold) else $error("entry changed while stalled");
    property p_take; take |=> entry_valid && entry_qid == $past(cmpt_qid); endproperty
    a_take: assert property (p_take) else $error("entry queue id wrong");
    property p_pass; take && cmpt_size == 2'h3 && both7 |=> entry_data == $past(cmpt_data);
    endproperty
    a_pass: assert property (p_pass) else $error("excluded bits not passed");
    property p_clear; take && cmpt_size == 2'h0 && low |=> entry_data[511:64] == '0; endproperty
    a_clear: assert property (p_clear) else $error("bits above 8B not cleared");
    property p_room; !entry_valid |-> cmpt_ready; endproperty
    a_room: assert property (p_room) else $error("empty buffer refused");
    property p_one; irq_valid |=> !(irq_valid && irq_qid == $past(irq_qid)); endproperty
    a_one: assert property (p_one) else $error("second interrupt outstanding");
    property p_gap; cidx_upd_valid |=> !(irq_valid && irq_qid == $past(cidx_upd_qid)); endproperty
    a_gap: assert property (p_gap) else $error("fire in update cycle");
    property p_arm; !armed_r |-> !irq_valid && !stat_valid; endproperty
    a_arm: assert property (p_arm) else $error("fire before arming");
    property p_fmt; reg_rd && reg_addr == 12'hBDC |=>
        reg_rdata == {7'h00, cem_pkg::ERR_POS[6], 7'h00, cem_pkg::COL_POS[6]}; endproperty
    a_fmt: assert property (p_fmt) else $error("last format register wrong");
    property p_unmap; reg_rd && !(reg_addr inside {[12'hBC4:12'hBDC]}) |=> reg_rdata == '0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_keep; !reg_rd |=> $stable(reg_rdata); endproperty
    a_keep: assert property (p_keep) else $error("read data moved");
    c_irq: cover property (irq_valid);
    c_full: cover property (cmpt_valid && !cmpt_ready);
    c_stall: cover property (entry_valid && !entry_ready ##1 entry_ready);
endmodule : cem_assertions
bind cem_top cem_assertions u_cem_assertions (.mclk, .nrst, .cmpt_valid, .cmpt_ready,
    .cmpt_data, .cmpt_qid, .cmpt_size, .stream_color_position_index,
    .stream_error_position_index, .cidx_upd_valid, .cidx_upd_qid, .entry_valid, .entry_ready,
    .entry_data, .entry_qid, .irq_valid, .irq_qid, .stat_valid, .reg_rd, .reg_addr, .reg_rdata);

// ==== tb/cem_partner.sv ====
// partner: user-side source of completion packets
`timescale 1ns/1ps
module cem_partner (
    input  wire logic         mclk,
    input  wire logic         cmpt_ready,
    output logic              cmpt_valid,
    output logic      [511:0] cmpt_data,
    output logic      [3:0]   cmpt_qid,
    output logic      [1:0]   cmpt_size,
    output logic              cmpt_user_trig,
    output logic      [2:0]   stream_color_position_index,
    output logic      [2:0]   stream_error_position_index
);
    initial begin
        {cmpt_valid, cmpt_data, cmpt_qid, cmpt_size, cmpt_user_trig} = '0;
        {stream_color_position_index, stream_error_position_index} = '0;
    end
    // whole beat held until taken; returns on the accepting edge
    task automatic send(input logic [511:0] d, input logic [3:0] q, input logic [1:0] s,
                        input logic t, input logic [2:0] ci, input logic [2:0] ei);
        cmpt_valid <= 1'b1;
        cmpt_data <= d;
        cmpt_qid <= q;
        cmpt_size <= s;
        cmpt_user_trig <= t;
        stream_color_position_index <= ci;
        stream_error_position_index <= ei;
        do @(posedge mclk); while (cmpt_ready !== 1'b1);
    endtask : send
    // released data, queue id and trigger lines show inverted junk so stale values cannot pass
    task automatic idle();
        cmpt_valid <= 1'b0;
        cmpt_data <= ~cmpt_data;
        cmpt_qid <= ~cmpt_qid;
        cmpt_user_trig <= ~cmpt_user_trig;
    endtask : idle
endmodule : cem_partner

// ==== tb/cem_top_bench.sv ====
// bench: self-checking run of the completion entry and moderation block
`timescale 1ns/1ps
module cem_top_bench;
    logic         mclk = 1'b0;
    logic         nrst = 1'b0;
    logic         cmpt_valid, cmpt_ready, cmpt_user_trig, entry_valid, entry_ready;
    logic [511:0] cmpt_data, entry_data;
    logic [3:0]   cmpt_qid, cidx_upd_qid, entry_qid, irq_qid, stat_qid;
    logic [1:0]   cmpt_size;
    logic [2:0]   stream_color_position_index, stream_error_position_index, cidx_upd_mode;
    logic         cidx_upd_valid, cidx_upd_full, cidx_upd_en_int, cidx_upd_en_stat;
    logic [15:0]  cidx_upd_value, cidx_upd_threshold, cidx_upd_timer, queue_color;
    logic         timer_tick, irq_valid, stat_valid, reg_rd, rd_q, stall;
    logic [11:0]  reg_addr;
    logic [31:0]  reg_rdata, seed;
    logic [515:0] exp_e[$];
    logic [31:0]  exp_r[$];
    logic [4:0]   exp_i[$], exp_s[$];
    int           error_cnt, compares, cyc;
    always #5 mclk = ~mclk;
    cem_top u_cem_top (.mclk, .nrst, .cmpt_valid, .cmpt_ready, .cmpt_data, .cmpt_qid, .cmpt_size,
        .cmpt_user_trig, .stream_color_position_index, .stream_error_position_index,
        .cidx_upd_valid, .cidx_upd_qid, .cidx_upd_value, .cidx_upd_full, .cidx_upd_mode,
        .cidx_upd_en_int, .cidx_upd_en_stat, .cidx_upd_threshold, .cidx_upd_timer,
        .queue_color, .timer_tick, .entry_valid, .entry_ready, .entry_data, .entry_qid,
        .irq_valid, .irq_qid, .stat_valid, .stat_qid, .reg_rd, .reg_addr, .reg_rdata);
    cem_partner u_cem_partner (.mclk, .cmpt_ready, .cmpt_valid, .cmpt_data, .cmpt_qid,
        .cmpt_size, .cmpt_user_trig, .stream_color_position_index, .stream_error_position_index);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string n, input logic [515:0] e, input logic [515:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task automatic send(input logic [3:0] q, input logic t);
        logic [511:0] d;
        logic [511:0] x;
        logic [2:0]   ci;
        logic [2:0]   ei;
        logic [1:0]   s;
        d = {16{rnd()}};
        ci = 3'(rnd());
        ei = (ci == 3'h7) ? 3'h7 : ci + 3'h1;
        s = 2'(rnd());
        // options past the entry width switch the entry to 64 bytes
        if ((ci < 7 && cem_pkg::COL_POS[ci % 7] >= (64 << s))
            || (ei < 7 && cem_pkg::ERR_POS[ei % 7] >= (64 << s))) s = 2'h3;
        x = d & ({512{1'b1}} >> (512 - (64 << s)));
        if (ci != 3'h7) x[cem_pkg::COL_POS[ci % 7]] = queue_color[q];
        if (ei != 3'h7) x[cem_pkg::ERR_POS[ei % 7]] = 1'b0;
        exp_e.push_back({q, x});
        u_cem_partner.send(d, q, s, t, ci, ei);
    endtask : send
    task automatic upd(input logic [3:0] q, input logic [15:0] v, input logic f,
                       input logic [2:0] md, input logic en, input logic [15:0] tm = 16'hFFFF);
        cidx_upd_valid <= 1'b1;
        cidx_upd_qid <= q;
        cidx_upd_value <= v;
        cidx_upd_full <= f;
        cidx_upd_mode <= md;
        cidx_upd_en_int <= en;
        cidx_upd_en_stat <= en;
        cidx_upd_threshold <= 16'h0000;
        cidx_upd_timer <= tm;
        @(posedge mclk);
        cidx_upd_valid <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask : upd
    // ****************************************
    // monitors and timeout
    // ****************************************
    always @(posedge mclk) begin
        rd_q <= reg_rd;
        entry_ready <= stall ? 1'b0 : 1'(rnd());
        timer_tick <= 1'(rnd());
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    always @(negedge mclk) begin
        if (rd_q) chk("reg_rdata", exp_r.size() ? exp_r.pop_front() : '1, reg_rdata);
        if (entry_valid && entry_ready)
            chk("entry", exp_e.size() ? exp_e.pop_front() : '1, {entry_qid, entry_data});
        if (irq_valid) chk("irq_qid", exp_i.size() ? exp_i.pop_front() : 5'h10, irq_qid);
        if (stat_valid) chk("stat_qid", exp_s.size() ? exp_s.pop_front() : 5'h10, stat_qid);
    end
    initial begin
        {cidx_upd_valid, cidx_upd_full, cidx_upd_en_int, cidx_upd_en_stat} = '0;
        {timer_tick, reg_rd, rd_q, stall, entry_ready, reg_addr} = '0;
        {cidx_upd_qid, cidx_upd_mode, cidx_upd_value, cidx_upd_threshold, cidx_upd_timer} = '0;
        seed = 32'h000128A6;
        queue_color = 16'(rnd());
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        for (int n = 0; n < 8; n++) begin
            reg_rd <= 1'b1;
            reg_addr <= 12'hBC4 + 12'(4 * n);
            exp_r.push_back(n < 7 ? {7'h00, cem_pkg::ERR_POS[n % 7], 7'h00,
                                     cem_pkg::COL_POS[n % 7]} : 32'h0);
            @(posedge mclk);
        end
        reg_rd <= 1'b0;
        $display("test registers done");
        for (int i = 0; i < 24; i++) send(4'h7 + 4'(rnd() % 9), 1'(rnd()));
        u_cem_partner.idle();
        while (exp_e.size() != 0) @(posedge mclk);
        $display("test formatting done");
        stall <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 8; i++) send(4'hF, 1'b0);
        fork
            send(4'hF, 1'b1);
            begin
                repeat (3) @(negedge mclk);
                chk("cmpt_ready", 0, cmpt_ready);
                stall <= 1'b0;
            end
        join
        u_cem_partner.idle();
        while (exp_e.size() != 0) @(posedge mclk);
        $display("test buffer full done");
        // queue m uses mode m; queue 6 is every-mode with both enables off
        for (int m = 0; m < 7; m++) begin
            upd(4'(m), 16'h0000, 1'b1, (m == 6) ? 3'h1 : 3'(m), m != 6);
            if (m inside {1, 2, 5}) exp_i.push_back(5'(m));
            if (m inside {1, 2, 5}) exp_s.push_back(5'(m));
            send(4'(m), 1'b0);
            u_cem_partner.idle();
            repeat (12) @(posedge mclk);
            if (m inside {3, 4}) exp_i.push_back(5'(m));
            if (m inside {3, 4}) exp_s.push_back(5'(m));
            send(4'(m), 1'b1);
            u_cem_partner.idle();
            repeat (12) @(posedge mclk);
            if (m inside {1, 2, 5}) exp_i.push_back(5'(m));
            if (m inside {1, 2, 5}) exp_s.push_back(5'(m));
            upd(4'(m), 16'h0001, 1'b0, 3'h0, 1'b0);
            chk("irq left", 0, exp_i.size());
            chk("stat left", 0, exp_s.size());
        end
        // queue 4 timer mode, one unread entry, expiry on first tick
        for (int k = 0; k < 2; k++) begin
            exp_i.push_back(5'h04);
            exp_s.push_back(5'h04);
            upd(4'h4, 16'h0001, 1'b1, 3'h4, 1'b1, 16'h0000);
        end
        chk("irq left", 0, exp_i.size());
        $display("test moderation done");
        final_report();
    end
endmodule : cem_top_bench
